// File: src/ehcic_command_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "ehcic_defs.svh"

module ehcic_command_reg
    import ehcic_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Register port
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire ehcic_pkg::ehcic_addr_t reg_addr,
    input  wire ehcic_pkg::ehcic_word_t reg_wdata,
    output ehcic_pkg::ehcic_word_t     reg_rdata,
    output logic                       reg_rvalid,
    // Schedule engine
    input  wire logic                  uframe_tick,
    input  wire logic                  evict_done,
    input  wire logic                  async_advance_irq_enable,
    input  wire logic                  irq_request,
    // Controls out
    output logic                       run_stop,
    output logic                       async_sched_enable,
    output logic                       periodic_sched_enable,
    output logic [1:0]                 frame_list_size,
    output ehcic_pkg::ehcic_itc_t      irq_threshold,
    output logic                       evict_request,
    output logic                       async_advance_flag,
    output logic                       halted_flag,
    output logic                       core_reset,
    output logic                       port_reset,
    output logic                       irq
);
    import ehcic_pkg::*;

    function automatic logic hits_cmd(input ehcic_addr_t addr);
        hits_cmd = (addr == `EHCIC_CMD_OFFSET);
    endfunction : hits_cmd

    ehcic_rst_t  rst_state_q;
    ehcic_rst_t  rst_state_d;
    logic [7:0]  rst_cnt_q;
    logic        cmd_wr;
    logic        in_reset;
    logic        rst_done;
    logic        door_q;
    logic        adv_pend_q;
    logic        thr_fired;
    logic        start_full;
    logic        start_light;
    ehcic_word_t rd_word;

    assign cmd_wr      = reg_wr && hits_cmd(reg_addr) && !in_reset;
    assign in_reset    = (rst_state_q != EHCIC_RST_IDLE);
    assign start_full  = cmd_wr && reg_wdata[`EHCIC_FRST_BIT];
    assign start_light = cmd_wr && !reg_wdata[`EHCIC_FRST_BIT]
                         && reg_wdata[`EHCIC_LRST_BIT] && `EHCIC_LIGHT_IMPL;

    // Reset sequencer
    always_comb begin
        rst_state_d = rst_state_q;
        rst_done    = 1'b0;
        unique case (rst_state_q)
            EHCIC_RST_IDLE: begin
                if (start_full) begin
                    rst_state_d = EHCIC_RST_FULL;
                end else if (start_light) begin
                    rst_state_d = EHCIC_RST_LIGHT;
                end
            end
            EHCIC_RST_FULL: begin
                if (rst_cnt_q == 8'h00) begin
                    rst_state_d = EHCIC_RST_IDLE;
                    rst_done    = 1'b1;
                end
            end
            EHCIC_RST_LIGHT: begin
                if (rst_cnt_q == 8'h00) begin
                    rst_state_d = EHCIC_RST_IDLE;
                    rst_done    = 1'b1;
                end
            end
            default: begin
                rst_state_d = EHCIC_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_state_q <= EHCIC_RST_IDLE;
        end else begin
            rst_state_q <= rst_state_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_q <= 8'h00;
        end else if (start_full) begin
            rst_cnt_q <= `EHCIC_FULL_RST_CYC - 8'h01;
        end else if (start_light) begin
            rst_cnt_q <= `EHCIC_LIGHT_RST_CYC - 8'h01;
        end else if (rst_cnt_q != 8'h00) begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
        end
    end

    // Core reset for both kinds; ports only on full reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_reset <= 1'b0;
            port_reset <= 1'b0;
        end else begin
            core_reset <= (rst_state_d != EHCIC_RST_IDLE);
            port_reset <= (rst_state_d == EHCIC_RST_FULL);
        end
    end

    // Run/stop and halted indication
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_stop    <= 1'b0;
            halted_flag <= 1'b1;
        end else begin
            if (start_full || start_light) begin
                run_stop <= 1'b0;
            end else if (cmd_wr) begin
                run_stop <= reg_wdata[`EHCIC_RUN_BIT];
            end
            halted_flag <= !run_stop;
        end
    end

    // Schedule enables
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            async_sched_enable    <= 1'b0;
            periodic_sched_enable <= 1'b0;
        end else if (start_full || start_light) begin
            async_sched_enable    <= 1'b0;
            periodic_sched_enable <= 1'b0;
        end else if (cmd_wr) begin
            async_sched_enable    <= reg_wdata[`EHCIC_ASE_BIT];
            periodic_sched_enable <= reg_wdata[`EHCIC_PSE_BIT];
        end
    end

    // Frame list size, held at zero unless programmable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frame_list_size <= `EHCIC_FLS_RST;
        end else if (start_full || start_light || !`EHCIC_FLS_PROG) begin
            frame_list_size <= `EHCIC_FLS_RST;
        end else if (cmd_wr) begin
            frame_list_size <= reg_wdata[`EHCIC_FLS_HI:`EHCIC_FLS_LO];
        end
    end

    // Interrupt threshold
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_threshold <= `EHCIC_ITC_RST;
        end else if (start_full || start_light) begin
            irq_threshold <= `EHCIC_ITC_RST;
        end else if (cmd_wr) begin
            irq_threshold <= reg_wdata[`EHCIC_ITC_HI:`EHCIC_ITC_LO];
        end
    end

    // Doorbell: a new ring wins over the completion clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            door_q <= 1'b0;
        end else if (start_full || start_light) begin
            door_q <= 1'b0;
        end else if (cmd_wr && reg_wdata[`EHCIC_DOOR_BIT]) begin
            door_q <= 1'b1;
        end else if (evict_done) begin
            door_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evict_request      <= 1'b0;
            async_advance_flag <= 1'b0;
        end else begin
            evict_request      <= door_q && !evict_done && !in_reset;
            async_advance_flag <= door_q && evict_done && !in_reset;
        end
    end

    // Advance interrupt held until the throttle fires
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            adv_pend_q <= 1'b0;
        end else if (in_reset) begin
            adv_pend_q <= 1'b0;
        end else if (async_advance_flag && async_advance_irq_enable) begin
            adv_pend_q <= 1'b1;
        end else if (thr_fired) begin
            adv_pend_q <= 1'b0;
        end
    end

    ehcic_irq_throttle u_throttle (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .clear         (in_reset),
        .threshold     (irq_threshold),
        .uframe_tick   (uframe_tick),
        .event_pending (adv_pend_q || irq_request),
        .irq           (irq),
        .fired         (thr_fired)
    );

    // Read-back; reserved bits read as zero
    always_comb begin
        rd_word                                 = 32'h0000_0000;
        rd_word[`EHCIC_ITC_HI:`EHCIC_ITC_LO]     = irq_threshold;
        rd_word[`EHCIC_LRST_BIT]                = (rst_state_q == EHCIC_RST_LIGHT)
                                                  && `EHCIC_LIGHT_IMPL;
        rd_word[`EHCIC_DOOR_BIT]                = door_q;
        rd_word[`EHCIC_ASE_BIT]                 = async_sched_enable;
        rd_word[`EHCIC_PSE_BIT]                 = periodic_sched_enable;
        rd_word[`EHCIC_FLS_HI:`EHCIC_FLS_LO]     = frame_list_size;
        rd_word[`EHCIC_FRST_BIT]                = (rst_state_q == EHCIC_RST_FULL);
        rd_word[`EHCIC_RUN_BIT]                 = run_stop;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= hits_cmd(reg_addr) ? rd_word : 32'h0000_0000;
            end
        end
    end

endmodule : ehcic_command_reg

`default_nettype wire

// File: inc/ehcic_defs.svh
`ifndef EHCIC_DEFS_SVH
`define EHCIC_DEFS_SVH

// Register offset
`define EHCIC_CMD_OFFSET      8'h20

// Field positions
`define EHCIC_RUN_BIT         0
`define EHCIC_FRST_BIT        1
`define EHCIC_FLS_LO          2
`define EHCIC_FLS_HI          3
`define EHCIC_PSE_BIT         4
`define EHCIC_ASE_BIT         5
`define EHCIC_DOOR_BIT        6
`define EHCIC_LRST_BIT        7
`define EHCIC_ITC_LO          16
`define EHCIC_ITC_HI          23

// Reset values
`define EHCIC_ITC_RST         8'h08
`define EHCIC_FLS_RST         2'h0

// Implementation options
`define EHCIC_LIGHT_IMPL      1'b1
`define EHCIC_FLS_PROG        1'b0

// Reset lengths in ref_clk cycles; microframes per millisecond
`define EHCIC_FULL_RST_CYC    8'h10
`define EHCIC_LIGHT_RST_CYC   8'h08
`define EHCIC_UFRAME_PER_MS   8'h08

`endif

// File: inc/ehcic_pkg.sv
package ehcic_pkg;

    typedef enum logic [1:0] {
        EHCIC_RST_IDLE  = 2'b00,
        EHCIC_RST_FULL  = 2'b01,
        EHCIC_RST_LIGHT = 2'b10
    } ehcic_rst_t;

    typedef logic [7:0]  ehcic_addr_t;
    typedef logic [31:0] ehcic_word_t;
    typedef logic [7:0]  ehcic_itc_t;

endpackage : ehcic_pkg

// File: src/ehcic_irq_throttle.sv
`timescale 1ns/1ps
`default_nettype none

module ehcic_irq_throttle
    import ehcic_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // Control
    input  wire logic          clear,
    input  wire ehcic_pkg::ehcic_itc_t threshold,
    input  wire logic          uframe_tick,
    input  wire logic          event_pending,
    // Result
    output logic               irq,
    output logic               fired
);
    import ehcic_pkg::*;

    logic [7:0] uframe_cnt_q;
    logic       period_done;

    // Zero threshold is undefined; treat it like one microframe
    assign period_done = (uframe_cnt_q != 8'h00) && (uframe_cnt_q >= threshold);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            uframe_cnt_q <= 8'h00;
        end else if (clear || fired) begin
            uframe_cnt_q <= 8'h00;
        end else if (uframe_tick && !period_done) begin
            uframe_cnt_q <= uframe_cnt_q + 8'h01;
        end
    end

    // At most one interrupt per threshold period
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq   <= 1'b0;
            fired <= 1'b0;
        end else begin
            fired <= !clear && !fired && period_done && event_pending;
            irq   <= !clear && !fired && period_done && event_pending;
        end
    end

endmodule : ehcic_irq_throttle

`default_nettype wire

// File: verif/ehcic_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ehcic_checker
    import ehcic_pkg::*;
(
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    // Register port
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire ehcic_pkg::ehcic_addr_t reg_addr,
    input wire ehcic_pkg::ehcic_word_t reg_wdata,
    input wire ehcic_pkg::ehcic_word_t reg_rdata,
    input wire logic                   reg_rvalid,
    // Engine and controls
    input wire logic                   evict_done,
    input wire logic                   run_stop,
    input wire logic [1:0]             frame_list_size,
    input wire ehcic_pkg::ehcic_itc_t  irq_threshold,
    input wire logic                   evict_request,
    input wire logic                   async_advance_flag,
    input wire logic                   halted_flag,
    input wire logic                   core_reset,
    input wire logic                   port_reset,
    input wire logic                   irq
);
    import ehcic_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    thr_write_a: assert property (reg_wr && reg_addr == 8'h20 && !core_reset
        && !reg_wdata[1] && !reg_wdata[7] |=> irq_threshold == $past(reg_wdata[23:16]))
        else $error("threshold not taken from write");
    fls_zero_a: assert property (frame_list_size == 2'h0)
        else $error("frame list size not zero");
    rsv_read_a: assert property (reg_rvalid |-> reg_rdata[31:24] == 8'h00
        && reg_rdata[15:8] == 8'h00 && reg_rdata[3:2] == 2'h0)
        else $error("reserved bits read nonzero");
    halt_track_a: assert property (halted_flag == !$past(run_stop))
        else $error("halted flag does not follow run");
    adv_flag_a: assert property (async_advance_flag |-> $past(evict_request)
        && $past(evict_done))
        else $error("advance flag without eviction");
    irq_pulse_a: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    full_len_a: assert property ($rose(port_reset) |-> port_reset[*8] ##1 port_reset[*7]
        ##[1:3] !port_reset)
        else $error("full reset length wrong");
    light_len_a: assert property ($rose(core_reset) && !port_reset |->
        (core_reset && !port_reset)[*7] ##[1:3] !core_reset)
        else $error("light reset length wrong");
endmodule : ehcic_checker

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ehcic_pkg::*;
    logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    ehcic_addr_t reg_addr = 8'h00;
    ehcic_word_t reg_wdata = 32'h0, reg_rdata;
    logic        uframe_tick = 1'b0, evict_done = 1'b0;
    logic        async_advance_irq_enable = 1'b0, irq_request = 1'b0;
    logic        reg_rvalid, run_stop, async_sched_enable, periodic_sched_enable;
    logic [1:0]  frame_list_size;
    ehcic_itc_t  irq_threshold;
    logic        evict_request, async_advance_flag, halted_flag, core_reset, port_reset, irq;
    int          n_fail = 0, total_checks = 0, n_irq = 0;

    ehcic_command_reg uut (
        .ref_clk                  (ref_clk),
        .rstn                     (rstn),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_rdata                (reg_rdata),
        .reg_rvalid               (reg_rvalid),
        .uframe_tick              (uframe_tick),
        .evict_done               (evict_done),
        .async_advance_irq_enable (async_advance_irq_enable),
        .irq_request              (irq_request),
        .run_stop                 (run_stop),
        .async_sched_enable       (async_sched_enable),
        .periodic_sched_enable    (periodic_sched_enable),
        .frame_list_size          (frame_list_size),
        .irq_threshold            (irq_threshold),
        .evict_request            (evict_request),
        .async_advance_flag       (async_advance_flag),
        .halted_flag              (halted_flag),
        .core_reset               (core_reset),
        .port_reset               (port_reset),
        .irq                      (irq)
    );

    initial forever #2 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (irq === 1'b1) n_irq++;

    task automatic cmp(input ehcic_word_t got, input ehcic_word_t exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input ehcic_addr_t a, input ehcic_word_t d);
        @(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge ref_clk) reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input ehcic_addr_t a, input ehcic_word_t m, input ehcic_word_t e);
        @(negedge ref_clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge ref_clk) reg_rd = 1'b0;
        cmp(reg_rvalid, 1);
        cmp(reg_rdata & m, e & m);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge ref_clk) uframe_tick = 1'b1;
            @(negedge ref_clk) uframe_tick = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
    endtask : ticks

    task automatic t_irq;
        rd(8'h20, 32'hffffffff, 32'h00080000);
        wr(8'h20, 32'h00020000);
        n_irq = 0;
        irq_request = 1'b1;
        ticks(8);
        irq_request = 1'b0;
        cmp(n_irq, 4);
        $display("test irq done");
    endtask : t_irq

    task automatic t_door;
        wr(8'h20, 32'h00080060);
        rd(8'h20, 32'hffffffff, 32'h00080060);
        cmp(evict_request, 1);
        async_advance_irq_enable = 1'b1;
        @(negedge ref_clk) evict_done = 1'b1;
        @(negedge ref_clk) evict_done = 1'b0;
        cmp(async_advance_flag, 1);
        rd(8'h20, 32'hffffffff, 32'h00080020);
        n_irq = 0;
        ticks(8);
        cmp(n_irq, 1);
        async_advance_irq_enable = 1'b0;
        $display("test doorbell done");
    endtask : t_door

    task automatic t_light;
        wr(8'h20, 32'h00080080);
        rd(8'h20, 32'h00000080, 32'h00000080);
        cmp({core_reset, port_reset}, 2'b10);
        repeat (12) @(negedge ref_clk);
        rd(8'h20, 32'h00000080, 32'h0);
        $display("test light reset done");
    endtask : t_light

    task automatic t_full;
        wr(8'h20, 32'h0040003d);
        rd(8'h20, 32'hffffffff, 32'h00400031);
        cmp({run_stop, async_sched_enable, periodic_sched_enable}, 3'b111);
        wr(8'h20, 32'h00400002);
        rd(8'h20, 32'hffffffff, 32'h00080002);
        cmp({core_reset, port_reset}, 2'b11);
        wr(8'h20, 32'h00080001);
        repeat (20) @(negedge ref_clk);
        rd(8'h20, 32'hffffffff, 32'h00080000);
        $display("test full reset done");
    endtask : t_full

    task automatic t_unmapped;
        wr(8'h24, 32'h00000031);
        rd(8'h24, 32'hffffffff, 32'h0);
        rd(8'h20, 32'hffffffff, 32'h00080000);
        cmp({run_stop, halted_flag}, 2'b01);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial begin
        #40000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) rstn = 1'b1;
        t_irq();
        t_door();
        t_light();
        t_full();
        t_unmapped();
        wrap_up();
    end
endmodule : testbench

bind ehcic_command_reg ehcic_checker chk (
    .ref_clk            (ref_clk),
    .rstn               (rstn),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .reg_rvalid         (reg_rvalid),
    .evict_done         (evict_done),
    .run_stop           (run_stop),
    .frame_list_size    (frame_list_size),
    .irq_threshold      (irq_threshold),
    .evict_request      (evict_request),
    .async_advance_flag (async_advance_flag),
    .halted_flag        (halted_flag),
    .core_reset         (core_reset),
    .port_reset         (port_reset),
    .irq                (irq)
);

`default_nettype wire
